// ### eq_reclocker_chk.sv
// Checker on the path control ports
`timescale 1ns/1ps
`default_nettype none
module eq_reclocker_chk
   import eq_reclocker_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cable_eq_en,
   input wire logic trace_eq_en,
   input wire logic cable_adapt_en,
   input wire logic auto_search_mode,
   input wire logic fixed_boost_mode,
   input wire logic reclocker_en,
   input wire logic [2:0] first_output_src,
   input wire logic eye_capture_monitor_en,
   input wire logic [5:0] eye_phase_step,
   input wire logic [5:0] eye_volt_step
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_one_eq_on: assert property (!(cable_eq_en && trace_eq_en))
      else $error("both equalizers on");
   a_adapt_cable: assert property (cable_adapt_en |-> cable_eq_en)
      else $error("adapt without equalizer");
   a_trace_mode: assert property (auto_search_mode |->
      trace_eq_en && !fixed_boost_mode) else $error("trace modes clash");
   a_raw_no_eq: assert property (first_output_src == 3'(OUT_RAW) |->
      !cable_eq_en && !trace_eq_en) else $error("raw with equalizer on");
   a_rec_needs_cdr: assert property (first_output_src == 3'(OUT_REC) |->
      reclocker_en) else $error("recovered without reclocker");
   a_scan_origin: assert property ($rose(eye_capture_monitor_en) |->
      $past(eye_phase_step) == 6'h00 && $past(eye_volt_step) == 6'h00)
      else $error("scan origin");
   a_phase_step: assert property (eye_capture_monitor_en &&
      $past(eye_capture_monitor_en) && $changed(eye_phase_step) |->
      eye_phase_step == $past(eye_phase_step) + 6'h01) else $error("phase skip");
   a_volt_wrap: assert property (eye_capture_monitor_en &&
      $past(eye_capture_monitor_en) && $changed(eye_volt_step) |->
      $past(eye_phase_step) == EYE_LAST && eye_phase_step == 6'h00)
      else $error("volt step early");
   c_scan_end: cover property (eye_capture_monitor_en && eye_volt_step == EYE_LAST);
   c_auto: cover property (auto_search_mode);
   c_fixed: cover property (fixed_boost_mode);
endmodule
bind eq_reclocker_ctrl eq_reclocker_chk i_eq_reclocker_chk (.*);
`default_nettype wire

// ### eq_reclocker_ctrl.sv
// Serial path control: equalizers, route, reclocker, eye capture, output function
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module eq_reclocker_ctrl
   import eq_reclocker_pkg::*;
#(
   parameter int HIT_W = 16
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] route_sel_thermo,
   input wire logic [2:0] out_ctrl_thermo,
   input wire logic [2:0] rate_code_in,
   input wire logic cable_carrier_in,
   input wire logic trace_carrier_in,
   input wire logic trace_eq_error_in,
   input wire logic eye_hit_in,
   output logic cable_eq_en,
   output logic trace_eq_en,
   output logic cable_adapt_en,
   output logic auto_search_mode,
   output logic fixed_boost_mode,
   output logic [7:0] trace_boost,
   output logic cdr_broadcast_family,
   output logic div1001_en,
   output logic reclocker_en,
   output logic cdr_reset,
   output logic first_output_en,
   output logic second_output_en,
   output logic [2:0] first_output_src,
   output logic [2:0] second_output_src,
   output logic eye_capture_monitor_en,
   output logic [5:0] eye_phase_step,
   output logic [5:0] eye_volt_step,
   output logic [2:0] eye_volt_range
);
   typedef enum logic [1:0] {SRCH_IDLE, SRCH_SETTLE, SRCH_MEASURE, SRCH_HOLD} srch_e;
   typedef enum logic {EYE_IDLE, EYE_COUNT} eye_e;

   function automatic logic rate_adapts(rate_e r);
      return r inside {RATE_10G3125, RATE_2G97, RATE_5G94, RATE_11G88};
   endfunction

   function automatic logic rate_eye_ok(rate_e r);
      return r inside {RATE_2G97, RATE_5G94, RATE_11G88, RATE_10G3125};
   endfunction

   function automatic logic rate_le_3g(rate_e r);
      return r inside {RATE_125M, RATE_270M, RATE_1G485, RATE_2G97, RATE_1G25};
   endfunction

   pin_level_e route_pin_lvl;
   pin_level_e out_pin_lvl;
   logic [6:0] in_s1_r;
   logic [6:0] in_s2_r;
   logic [CTRL_W-1:0] ctrl_r;
   logic [7:0] fixed_boost_r;
   logic [15:0] eye_bits_r;
   logic [11:0] eye_addr_r;
   logic [7:0] boost_tbl_r [BOOST_TBL_NUM];
   logic [HIT_W-1:0] eye_mem [EYE_STEPS*EYE_STEPS];
   logic [31:0] rd_nxt;
   logic addr_ok;
   logic setup_ph;
   logic wr_en;
   logic [9:0] widx;
   logic [9:0] tidx;
   pin_level_e route_lvl;
   pin_level_e out_lvl;
   rate_e rate;
   logic sel_trace;
   logic fam_bc;
   logic eq_byp;
   logic recl;
   logic auto_sel;
   logic eye_ok;
   logic carrier;
   logic carrier_d_r;
   logic carrier_rise;
   logic fam_prev_r;
   logic fam_chg_r;
   logic [15:0] rst_cnt_r;
   out_src_e data_src;
   out_src_e first_nxt;
   out_src_e second_nxt;
   srch_e srch_r;
   logic [3:0] idx_r;
   logic [3:0] best_idx_r;
   logic [15:0] cnt_r;
   logic [15:0] err_r;
   logic [15:0] best_err_r;
   logic srch_on;
   logic [7:0] boost_nxt;
   eye_e eye_r;
   logic [15:0] bit_cnt_r;
   logic [HIT_W-1:0] hit_cnt_r;
   logic [HIT_W-1:0] hit_nxt;
   logic [15:0] bit_last;
   logic pt_end;
   logic [7:0] heo_r;
   logic [7:0] veo_r;
   logic eye_done_r;

   four_level_pin u_route_pin (
      .pclk(pclk),
      .presetn(presetn),
      .thermo(route_sel_thermo),
      .level(route_pin_lvl)
   );

   four_level_pin u_out_pin (
      .pclk(pclk),
      .presetn(presetn),
      .thermo(out_ctrl_thermo),
      .level(out_pin_lvl)
   );

   // Input synchroniser
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         in_s1_r <= 7'h00;
         in_s2_r <= 7'h00;
      end
      else
      begin
         in_s1_r <= {eye_hit_in, trace_eq_error_in, trace_carrier_in, cable_carrier_in,
            rate_code_in};
         in_s2_r <= in_s1_r;
      end
   end

   // Path decode
   always_comb
   begin
      rate = rate_e'(in_s2_r[2:0]);
      route_lvl = ctrl_r[CTRL_ROUTE_OVR] ? pin_level_e'(ctrl_r[CTRL_ROUTE_VAL +: 2])
         : route_pin_lvl;
      out_lvl = ctrl_r[CTRL_OUT_OVR] ? pin_level_e'(ctrl_r[CTRL_OUT_VAL +: 2])
         : out_pin_lvl;
      sel_trace = route_lvl inside {LVL_R, LVL_L};
      fam_bc = !sel_trace || ctrl_r[CTRL_TRACE_BC];
      eq_byp = (out_lvl == LVL_H) || ctrl_r[CTRL_EQ_BYPASS];
      recl = (sel_trace ? (rate != RATE_1G25) : (rate != RATE_125M))
         && (out_lvl inside {LVL_F, LVL_R});
      auto_sel = ctrl_r[CTRL_MODE_OVR] ? ctrl_r[CTRL_MODE_AUTO] : rate_adapts(rate);
      eye_ok = rate_eye_ok(rate);
      carrier = sel_trace ? in_s2_r[4] : in_s2_r[3];
      carrier_rise = carrier && !carrier_d_r;
      unique case (out_lvl)
         LVL_H: data_src = OUT_RAW;
         LVL_L: data_src = OUT_EQ;
         default: data_src = recl ? OUT_REC : OUT_EQ;
      endcase
      first_nxt = (route_lvl == LVL_R) ? OUT_OFF : data_src;
      if (route_lvl == LVL_F)
         second_nxt = OUT_OFF;
      else if (out_lvl == LVL_R)
         second_nxt = rate_le_3g(rate) ? OUT_CLK_FULL : OUT_CLK_297;
      else
         second_nxt = data_src;
      srch_on = sel_trace && !eq_byp && auto_sel;
      if (!auto_sel)
         boost_nxt = fixed_boost_r;
      else if (srch_r == SRCH_HOLD)
         boost_nxt = boost_tbl_r[best_idx_r];
      else
         boost_nxt = boost_tbl_r[idx_r];
   end

   // Path outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cable_eq_en <= 1'b0;
         trace_eq_en <= 1'b0;
         cable_adapt_en <= 1'b0;
         auto_search_mode <= 1'b0;
         fixed_boost_mode <= 1'b0;
         trace_boost <= 8'h00;
         cdr_broadcast_family <= 1'b1;
         div1001_en <= 1'b0;
         reclocker_en <= 1'b0;
         first_output_en <= 1'b0;
         second_output_en <= 1'b0;
         first_output_src <= OUT_OFF;
         second_output_src <= OUT_OFF;
         eye_capture_monitor_en <= 1'b0;
      end
      else
      begin
         cable_eq_en <= !sel_trace && !eq_byp;
         trace_eq_en <= sel_trace && !eq_byp;
         cable_adapt_en <= !sel_trace && !eq_byp;
         auto_search_mode <= srch_on;
         fixed_boost_mode <= sel_trace && !eq_byp && !auto_sel;
         trace_boost <= boost_nxt;
         cdr_broadcast_family <= fam_bc;
         div1001_en <= fam_bc && (rate inside {RATE_1G485, RATE_2G97, RATE_5G94,
            RATE_11G88});
         reclocker_en <= recl;
         first_output_en <= first_nxt != OUT_OFF;
         second_output_en <= second_nxt != OUT_OFF;
         first_output_src <= first_nxt;
         second_output_src <= second_nxt;
         eye_capture_monitor_en <= eye_ok && (eye_r == EYE_COUNT);
      end
   end

   // Recovery loop reset on carrier return after a family change
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         carrier_d_r <= 1'b0;
         fam_prev_r <= 1'b1;
         fam_chg_r <= 1'b0;
         rst_cnt_r <= 16'h0000;
         cdr_reset <= 1'b0;
      end
      else
      begin
         carrier_d_r <= carrier;
         fam_prev_r <= fam_bc;
         if (fam_bc != fam_prev_r)
            fam_chg_r <= 1'b1;
         else if (carrier_rise)
            fam_chg_r <= 1'b0;
         if (carrier_rise && (fam_chg_r || (fam_bc != fam_prev_r)))
            rst_cnt_r <= 16'(CDR_RST_CYC);
         else if (rst_cnt_r != 16'h0000)
            rst_cnt_r <= rst_cnt_r - 16'h0001;
         cdr_reset <= ctrl_r[CTRL_CDR_RESET] || (rst_cnt_r != 16'h0000);
      end
   end

   // Trace auto search over the boost table
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         srch_r <= SRCH_IDLE;
         idx_r <= 4'h0;
         best_idx_r <= 4'h0;
         cnt_r <= 16'h0000;
         err_r <= 16'h0000;
         best_err_r <= 16'hFFFF;
      end
      else if (!srch_on || carrier_rise)
      begin
         srch_r <= SRCH_IDLE;
         idx_r <= 4'h0;
      end
      else
      begin
         unique case (srch_r)
            SRCH_IDLE:
            begin
               srch_r <= SRCH_SETTLE;
               idx_r <= 4'h0;
               cnt_r <= 16'h0000;
               best_err_r <= 16'hFFFF;
            end
            SRCH_SETTLE:
            begin
               if (cnt_r == 16'(SETTLE_CYC - 1))
               begin
                  srch_r <= SRCH_MEASURE;
                  cnt_r <= 16'h0000;
                  err_r <= 16'h0000;
               end
               else
                  cnt_r <= cnt_r + 16'h0001;
            end
            SRCH_MEASURE:
            begin
               if (in_s2_r[5] && err_r != 16'hFFFF)
                  err_r <= err_r + 16'h0001;
               if (cnt_r == 16'(DWELL_CYC - 1))
               begin
                  cnt_r <= 16'h0000;
                  if (err_r < best_err_r)
                  begin
                     best_err_r <= err_r;
                     best_idx_r <= idx_r;
                  end
                  if (idx_r == 4'(BOOST_TBL_NUM - 1))
                     srch_r <= SRCH_HOLD;
                  else
                  begin
                     idx_r <= idx_r + 4'h1;
                     srch_r <= SRCH_SETTLE;
                  end
               end
               else
                  cnt_r <= cnt_r + 16'h0001;
            end
            SRCH_HOLD: srch_r <= SRCH_HOLD;
         endcase
      end
   end

   // Eye capture scan
   always_comb
   begin
      hit_nxt = hit_cnt_r + HIT_W'(in_s2_r[6]);
      bit_last = (eye_bits_r == 16'h0000) ? 16'h0000 : eye_bits_r - 16'h0001;
      pt_end = (eye_r == EYE_COUNT) && (bit_cnt_r >= bit_last);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         eye_r <= EYE_IDLE;
         eye_phase_step <= 6'h00;
         eye_volt_step <= 6'h00;
         bit_cnt_r <= 16'h0000;
         hit_cnt_r <= '0;
         heo_r <= 8'h00;
         veo_r <= 8'h00;
         eye_done_r <= 1'b0;
      end
      else if (eye_r == EYE_IDLE)
      begin
         if (wr_en && paddr == EYE_CTRL_OFF && pwdata[EYE_START] && eye_ok)
         begin
            eye_r <= EYE_COUNT;
            eye_phase_step <= 6'h00;
            eye_volt_step <= 6'h00;
            bit_cnt_r <= 16'h0000;
            hit_cnt_r <= '0;
            heo_r <= 8'h00;
            veo_r <= 8'h00;
            eye_done_r <= 1'b0;
         end
      end
      else if (!eye_ok)
         eye_r <= EYE_IDLE;
      else if (pt_end)
      begin
         bit_cnt_r <= 16'h0000;
         hit_cnt_r <= '0;
         if (hit_nxt == '0 && eye_volt_step == EYE_MID)
            heo_r <= heo_r + 8'h01;
         if (hit_nxt == '0 && eye_phase_step == EYE_MID)
            veo_r <= veo_r + 8'h01;
         eye_phase_step <= eye_phase_step + 6'h01;
         if (eye_phase_step == EYE_LAST)
         begin
            eye_volt_step <= eye_volt_step + 6'h01;
            if (eye_volt_step == EYE_LAST)
            begin
               eye_r <= EYE_IDLE;
               eye_done_r <= 1'b1;
            end
         end
      end
      else
      begin
         bit_cnt_r <= bit_cnt_r + 16'h0001;
         hit_cnt_r <= hit_nxt;
      end
   end

   // Hit grid storage
   always_ff @(posedge pclk)
   begin
      if (pt_end && eye_ok)
         eye_mem[{eye_volt_step, eye_phase_step}] <= hit_nxt;
   end

   // APB decode and read mux
   always_comb
   begin
      setup_ph = psel && !penable;
      widx = paddr[11:2];
      tidx = widx - BOOST_TBL_IDX;
      addr_ok = (paddr[1:0] == 2'h0) && ((paddr <= STATUS_OFF)
         || (widx >= BOOST_TBL_IDX && tidx < 10'(BOOST_TBL_NUM)));
      wr_en = psel && penable && pready && pwrite && addr_ok;
      rd_nxt = 32'h0000_0000;
      unique case (paddr)
         CTRL_OFF: rd_nxt[CTRL_W-1:0] = ctrl_r;
         FIXED_BOOST_OFF: rd_nxt[7:0] = fixed_boost_r;
         EYE_CTRL_OFF: rd_nxt = {eye_bits_r, 9'h000, eye_volt_range, 4'h0};
         EYE_STAT_OFF: rd_nxt = {8'h00, veo_r, heo_r, 5'h00, eye_ok, eye_done_r,
            eye_r == EYE_COUNT};
         EYE_ADDR_OFF: rd_nxt[11:0] = eye_addr_r;
         EYE_DATA_OFF: rd_nxt[HIT_W-1:0] = eye_mem[eye_addr_r];
         STATUS_OFF: rd_nxt = {18'h00000, srch_r, best_idx_r, sel_trace,
            route_pin_lvl, out_pin_lvl, rate};
         default:
            if (addr_ok)
               rd_nxt[7:0] = boost_tbl_r[tidx[3:0]];
      endcase
   end

   // APB response
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup_ph;
         pslverr <= setup_ph && !addr_ok;
         if (setup_ph && !pwrite && addr_ok)
            prdata <= rd_nxt;
      end
   end

   // Register writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= CTRL_RST;
         fixed_boost_r <= FIXED_BOOST_RST;
         eye_bits_r <= EYE_BITS_RST;
         eye_volt_range <= EYE_RANGE_RST;
         eye_addr_r <= EYE_ADDR_RST;
         for (int i = 0; i < BOOST_TBL_NUM; i++)
            boost_tbl_r[i] <= 8'(i) * BOOST_STEP_RST;
      end
      else if (wr_en)
      begin
         unique case (paddr)
            CTRL_OFF: ctrl_r <= pwdata[CTRL_W-1:0];
            FIXED_BOOST_OFF: fixed_boost_r <= pwdata[7:0];
            EYE_CTRL_OFF:
            begin
               eye_bits_r <= pwdata[EYE_BITS_LSB +: 16];
               eye_volt_range <= pwdata[EYE_RANGE_LSB +: 3];
            end
            EYE_ADDR_OFF: eye_addr_r <= pwdata[11:0];
            EYE_STAT_OFF, EYE_DATA_OFF, STATUS_OFF: ;
            default: boost_tbl_r[tidx[3:0]] <= pwdata[7:0];
         endcase
      end
   end
endmodule
`default_nettype wire

// ### eq_reclocker_ctrl_tb.sv
// Self-checking bench for the path control block
`timescale 1ns/1ps
`default_nettype none
module eq_reclocker_ctrl_tb import eq_reclocker_pkg::*;;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [2:0] route_sel_thermo = 3'h3, out_ctrl_thermo = 3'h3, rate = 3'h5;
   logic con = 1'b1, ton = 1'b1, noisy = 1'b0, pready, pslverr, er;
   logic cable_carrier_in, trace_carrier_in, trace_eq_error_in, eye_hit_in;
   logic [2:0] rate_code_in, first_output_src, second_output_src, eye_volt_range;
   logic cable_eq_en, trace_eq_en, cable_adapt_en, auto_search_mode, fixed_boost_mode;
   logic cdr_broadcast_family, div1001_en, reclocker_en, cdr_reset;
   logic first_output_en, second_output_en, eye_capture_monitor_en;
   logic [7:0] trace_boost, f, s;
   logic [5:0] eye_phase_step, eye_volt_step;
   int err_total = 0, samples_checked = 0, n;
   // Route, out level, rate, flags, first and second source
   logic [27:0] tbl [13] = '{28'h7355F33, 28'h3355730, 28'h137AA03, 28'h037BA33,
      28'h5355730, 28'h7751C11, 28'h7155F35, 28'h7135F34, 28'h7055C22, 28'h3305420,
      28'h3315630, 28'h3325730, 28'h0363822};
   eq_reclocker_ctrl i_eq_reclocker_ctrl (.*);
   serial_source_model i_serial_source_model (.cable_on(con), .trace_on(ton), .rate,
      .noisy, .trace_boost, .cable_carrier_in, .trace_carrier_in, .rate_code_in,
      .trace_eq_error_in, .eye_hit_in);
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
      samples_checked++;
      if (sv !== ev)
      begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, sv, ev);
      end
   endtask
   task automatic wt;
      repeat (8) @(posedge pclk);
   endtask
   task automatic scan;
      apb(1'b1, EYE_CTRL_OFF, 32'h0002_0051);
      repeat (2) @(posedge pclk);
      while (eye_capture_monitor_en === 1'b1)
         @(posedge pclk);
      apb(1'b0, EYE_STAT_OFF, 32'h0);
   endtask
   task automatic hold(input logic v, input int lim);
      n = 0;
      while (cdr_reset === v && n < lim)
      begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      forever #4 pclk = ~pclk;
   end
   initial
   begin
      #600000;
      err_total++;
      close_out;
   end
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      wt;
      chk(32'({first_output_en, second_output_en}), 32'h2);
      apb(1'b0, EYE_CTRL_OFF, 32'h0);
      chk(rd, 32'h0100_0070);
      apb(1'b0, 12'h10C, 32'h0);
      chk(rd, 32'h30);
      apb(1'b0, 12'h800, 32'h0);
      chk(32'(er), 32'h1);
      $display("end map");
      foreach (tbl[i])
      begin
         route_sel_thermo <= tbl[i][26:24];
         out_ctrl_thermo <= tbl[i][22:20];
         rate <= tbl[i][18:16];
         wt;
         f = {auto_search_mode, cable_eq_en, trace_eq_en, first_output_en, second_output_en,
            cdr_broadcast_family, reclocker_en, reclocker_en & div1001_en};
         s = {1'b0, first_output_en ? first_output_src : 3'h0, 1'b0,
            second_output_en ? second_output_src : 3'h0};
         chk(32'(f), 32'(tbl[i][15:8]));
         chk(32'(s), 32'(tbl[i][7:0]));
      end
      $display("end pin table");
      route_sel_thermo <= 3'h3;
      rate <= 3'h2;
      apb(1'b1, CTRL_OFF, 32'h001);
      apb(1'b1, FIXED_BOOST_OFF, 32'h5A);
      wt;
      chk(32'({trace_eq_en, fixed_boost_mode, trace_boost}), 32'h35A);
      apb(1'b1, CTRL_OFF, 32'h301);
      wt;
      chk(32'({auto_search_mode, fixed_boost_mode}), 32'h2);
      apb(1'b1, CTRL_OFF, 32'h039);
      wt;
      chk(32'({cable_eq_en, trace_eq_en, first_output_src}), 32'h1);
      apb(1'b1, CTRL_OFF, 32'h0C0);
      wt;
      chk(32'({cable_eq_en, first_output_en, second_output_en}), 32'h2);
      apb(1'b1, CTRL_OFF, 32'h081);
      wt;
      chk(32'({trace_eq_en, cdr_broadcast_family}), 32'h3);
      apb(1'b1, CTRL_OFF, 32'h400);
      wt;
      chk(32'(cdr_reset), 32'h1);
      apb(1'b1, CTRL_OFF, 32'h0);
      $display("end overrides");
      rate <= 3'h1;
      wt;
      apb(1'b1, EYE_CTRL_OFF, 32'h0002_0071);
      apb(1'b0, EYE_STAT_OFF, 32'h0);
      chk(32'(rd[2:0]), 32'h0);
      rate <= 3'h5;
      wt;
      scan;
      chk(32'(rd[23:0]), 32'h404006);
      chk(32'(eye_volt_range), 32'h5);
      noisy <= 1'b1;
      wt;
      scan;
      chk(32'(rd[23:0]), 32'h6);
      apb(1'b1, EYE_ADDR_OFF, 32'hFFF);
      apb(1'b0, EYE_DATA_OFF, 32'h0);
      chk(rd, 32'h2);
      $display("end eye capture");
      ton <= 1'b0;
      route_sel_thermo <= 3'h0;
      rate <= 3'h7;
      wt;
      ton <= 1'b1;
      hold(1'b0, 40);
      hold(1'b1, 200);
      chk(32'(n), 32'h64);
      repeat (16 * (125 + 1024) + 1000) @(posedge pclk);
      apb(1'b0, STATUS_OFF, 32'h0);
      chk(32'({auto_search_mode, trace_boost, rd[11:8]}), 32'h1303);
      $display("end search");
      close_out;
   end
endmodule
`default_nettype wire

// ### eq_reclocker_pkg.sv
// Shared constants and types for the equalizer and reclocker path control
package eq_reclocker_pkg;
   typedef enum logic [1:0] {LVL_L, LVL_R, LVL_F, LVL_H} pin_level_e;
   typedef enum logic [2:0] {RATE_125M, RATE_270M, RATE_1G485, RATE_2G97, RATE_5G94,
      RATE_11G88, RATE_1G25, RATE_10G3125} rate_e;
   typedef enum logic [2:0] {OUT_OFF, OUT_RAW, OUT_EQ, OUT_REC, OUT_CLK_FULL,
      OUT_CLK_297} out_src_e;

   // Register byte offsets
   localparam logic [11:0] CTRL_OFF = 12'h000;
   localparam logic [11:0] FIXED_BOOST_OFF = 12'h004;
   localparam logic [11:0] EYE_CTRL_OFF = 12'h008;
   localparam logic [11:0] EYE_STAT_OFF = 12'h00C;
   localparam logic [11:0] EYE_ADDR_OFF = 12'h010;
   localparam logic [11:0] EYE_DATA_OFF = 12'h014;
   localparam logic [11:0] STATUS_OFF = 12'h018;
   // Boost table: register index, byte address is four times it
   localparam logic [9:0] BOOST_TBL_IDX = 10'h040;
   localparam int BOOST_TBL_NUM = 16;

   // Control register fields
   localparam int CTRL_ROUTE_OVR = 0;
   localparam int CTRL_ROUTE_VAL = 1;
   localparam int CTRL_OUT_OVR = 3;
   localparam int CTRL_OUT_VAL = 4;
   localparam int CTRL_EQ_BYPASS = 6;
   localparam int CTRL_TRACE_BC = 7;
   localparam int CTRL_MODE_OVR = 8;
   localparam int CTRL_MODE_AUTO = 9;
   localparam int CTRL_CDR_RESET = 10;
   localparam int CTRL_W = 11;

   // Eye control and status fields
   localparam int EYE_START = 0;
   localparam int EYE_RANGE_LSB = 4;
   localparam int EYE_BITS_LSB = 16;
   localparam int EYE_BUSY = 0;
   localparam int EYE_DONE = 1;
   localparam int EYE_RATE_OK = 2;
   localparam int EYE_HEO_LSB = 8;
   localparam int EYE_VEO_LSB = 16;

   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
   localparam logic [7:0] FIXED_BOOST_RST = 8'h00;
   localparam logic [15:0] EYE_BITS_RST = 16'h0100;
   localparam logic [2:0] EYE_RANGE_RST = 3'h7;
   localparam logic [11:0] EYE_ADDR_RST = 12'h000;
   localparam logic [7:0] BOOST_STEP_RST = 8'h10;

   // Eye grid
   localparam int EYE_STEPS = 64;
   localparam logic [5:0] EYE_MID = 6'h20;
   localparam logic [5:0] EYE_LAST = 6'h3F;

   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SETTLE_NS = 1000;
   localparam int DWELL_NS = 8192;
   localparam int CDR_RST_NS = 800;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DWELL_CYC = DWELL_NS / CLK_PERIOD_NS;
   localparam int CDR_RST_CYC = (CDR_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### four_level_pin.sv
// Four-level configuration pin resolver
`timescale 1ns/1ps
`default_nettype none
module four_level_pin
   import eq_reclocker_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] thermo,
   output pin_level_e level
);
   logic [2:0] s1_r;
   logic [2:0] s2_r;

   // Two-stage synchroniser
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_r <= 3'h3;
         s2_r <= 3'h3;
      end
      else
      begin
         s1_r <= thermo;
         s2_r <= s1_r;
      end
   end

   // Thermometer decode, non-thermometer codes and float read as F
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         level <= LVL_F;
      else
      begin
         unique case (s2_r)
            3'h7: level <= LVL_H;
            3'h1: level <= LVL_R;
            3'h0: level <= LVL_L;
            default: level <= LVL_F;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### serial_source_model.sv
// Serial source model driving carrier, rate and sampler inputs
`timescale 1ns/1ps
`default_nettype none
module serial_source_model
#(
   parameter logic [7:0] BEST_BOOST = 8'h30
)
(
   input wire logic cable_on,
   input wire logic trace_on,
   input wire logic [2:0] rate,
   input wire logic noisy,
   input wire logic [7:0] trace_boost,
   output logic cable_carrier_in,
   output logic trace_carrier_in,
   output logic [2:0] rate_code_in,
   output logic trace_eq_error_in,
   output logic eye_hit_in
);
   assign cable_carrier_in = cable_on;
   assign trace_carrier_in = trace_on;
   assign rate_code_in = rate;
   // Errors vanish only at one boost
   assign trace_eq_error_in = (trace_boost != BEST_BOOST);
   assign eye_hit_in = noisy;
endmodule
`default_nettype wire
